// ### usg_unattended_start_guard.sv
// usg_unattended_start_guard: start protection for a motor drive output.
// assumes terminal pins are asynchronous to clk; reset release is power-up.
// Function
// RULE1: guard selected by code 13 and input on: ignore run present at power-up.
// RULE2: guard input off: run present at power-up starts the output.
// RULE3: guard on and run at power-up: raise guard error, enter trip.
// RULE4: guard trip shows the dedicated start guard trip code.
// RULE5: fault clear pulse while run still requested resumes running at once.
// RULE6: after undervoltage trip clear, the start guard check applies again.
// RULE7: controller should wait three seconds after power-up before run.
// RULE8: guard trip stays latched, output off, until run drops or clear.
`timescale 1ns/100ps

module usg_unattended_start_guard
    import usg_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic [4:0] input_function_selectors,
    input wire logic guard_terminal,
    input wire logic run_request,
    input wire logic fault_clear_input,
    input wire logic undervoltage_detect,
    output logic drive_run,
    output logic trip_active,
    output logic [7:0] trip_code
);

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers

    logic [3:0] pin_raw;
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    logic guard_s;
    logic run_s;
    logic clr_s;
    logic uv_s;

    assign pin_raw = {undervoltage_detect, fault_clear_input, run_request, guard_terminal};

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync_a <= USG_SYNC_RESET;
            sync_b <= USG_SYNC_RESET;
        end
        else if (clk_en)
        begin
            sync_a <= pin_raw;
            sync_b <= sync_a;
        end
    end

    assign guard_s = sync_b[0];
    assign run_s = sync_b[1];
    assign clr_s = sync_b[2];
    assign uv_s = sync_b[3];

    ////////////////////////////////////////////////////////////////////////
    // decoding

    logic guard_on;
    logic clr_prev;
    logic clear_done;

    assign guard_on = guard_s && (input_function_selectors == USG_GUARD_OPTION); // RULE1

    // clear acts when the terminal goes on then off
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            clr_prev <= 1'b0;
        else if (clk_en)
            clr_prev <= clr_s;
    end

    assign clear_done = clr_prev && !clr_s;

    // power-up decision, also reused after an undervoltage clear
    function automatic usg_state_t usg_start_target(input logic guard, input logic run);
        if (guard && run)
            return USG_GUARD_TRIP;
        else if (run)
            return USG_RUN;
        else
            return USG_IDLE;
    endfunction

    function automatic logic [7:0] usg_code_of(input usg_state_t s);
        case (s)
            USG_GUARD_TRIP: return USG_START_GUARD_TRIP_CODE;
            USG_UV_TRIP: return USG_UNDERVOLTAGE_TRIP_CODE;
            default: return USG_CODE_NONE;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state machine

    usg_state_t state;
    usg_state_t next_state;
    logic [1:0] settle_cnt;

    // wait until the synchronisers hold real pin levels before deciding
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            settle_cnt <= USG_SETTLE_RESET;
        else if (clk_en && state == USG_SETTLE && settle_cnt != USG_SETTLE_CYCLES)
            settle_cnt <= settle_cnt + 2'h1;
    end

    always_comb
    begin
        next_state = state;
        case (state)
            USG_SETTLE:
            begin
                if (settle_cnt == USG_SETTLE_CYCLES)
                    next_state = usg_start_target(guard_on, run_s); // RULE1 RULE2 RULE3
            end
            USG_IDLE:
            begin
                if (uv_s)
                    next_state = USG_UV_TRIP;
                else if (run_s)
                    next_state = USG_RUN;
            end
            USG_RUN:
            begin
                if (uv_s)
                    next_state = USG_UV_TRIP;
                else if (!run_s)
                    next_state = USG_IDLE;
            end
            USG_GUARD_TRIP:
            begin
                // latched; dropping run wins over a clear in the same cycle
                if (uv_s)
                    next_state = USG_UV_TRIP;
                else if (!run_s)
                    next_state = USG_IDLE; // RULE8
                else if (clear_done)
                    next_state = USG_RUN; // RULE5
            end
            USG_UV_TRIP:
            begin
                // clear treated like a fresh power-up, so the guard checks again
                if (clear_done && !uv_s)
                    next_state = usg_start_target(guard_on, run_s); // RULE6
            end
            default:
                next_state = USG_SETTLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            state <= USG_SETTLE;
        else if (clk_en)
            state <= next_state;
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs, aligned with state

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            drive_run <= USG_RUN_RESET;
            trip_active <= 1'b0;
            trip_code <= USG_CODE_NONE;
        end
        else if (clk_en)
        begin
            drive_run <= (next_state == USG_RUN); // RULE8
            trip_active <= (next_state == USG_GUARD_TRIP) || (next_state == USG_UV_TRIP);
            trip_code <= usg_code_of(next_state); // RULE4
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk);
    endclocking

    default disable iff (!nrst);

    logic at_decision;
    assign at_decision = clk_en && state == USG_SETTLE && settle_cnt == USG_SETTLE_CYCLES;

    a_guard_no_start: assert property (at_decision && guard_on && run_s |=> !drive_run) // RULE1
        else $error("run started at power-up with guard on");

    a_unguarded_start: assert property (at_decision && !guard_on && run_s |=> drive_run) // RULE2
        else $error("run not resumed at power-up with guard off");

    a_guard_trip_entry: assert property (at_decision && guard_on && run_s // RULE3
        |=> state == USG_GUARD_TRIP && trip_active)
        else $error("guard trip not entered at power-up");

    a_guard_code_shown: assert property (state == USG_GUARD_TRIP // RULE4
        |-> trip_code == USG_START_GUARD_TRIP_CODE && !drive_run)
        else $error("guard trip code not shown");

    a_clear_resumes_run: assert property (clk_en && state == USG_GUARD_TRIP && clear_done // RULE5
        && run_s && !uv_s |=> drive_run && trip_code == USG_CODE_NONE)
        else $error("clear did not resume running");

    a_uv_clear_guarded: assert property (clk_en && state == USG_UV_TRIP && clear_done // RULE6
        && !uv_s && guard_on && run_s |=> state == USG_GUARD_TRIP && !drive_run)
        else $error("guard check skipped after undervoltage clear");

    // the output is checked in the same cycle as the state; a clear one cycle later may legally run
    a_guard_trip_latch: assert property (clk_en && state == USG_GUARD_TRIP && run_s // RULE8
        && !clear_done && !uv_s |=> state == USG_GUARD_TRIP && !drive_run)
        else $error("guard trip released without cause");

    a_freeze_enable: assert property (!clk_en |=> $stable(state) && $stable(drive_run)
        && $stable(trip_code))
        else $error("state changed while clock enable low");

    c_guard_then_clear: cover property (state == USG_GUARD_TRIP ##1 state == USG_RUN);
    c_uv_then_guard: cover property (state == USG_UV_TRIP ##1 state == USG_GUARD_TRIP);
    c_unguarded_start: cover property (state == USG_SETTLE ##1 state == USG_RUN);
    c_guard_run_drop: cover property (state == USG_GUARD_TRIP ##1 state == USG_IDLE);

endmodule

// ### usg_pkg.sv
// usg_pkg: constants, codes and state type for the start guard.
// assumes one 125 MHz clock domain; the four terminal pins are synchronised in the module, the selectors are not.
package usg_pkg;

    // synchroniser depth and settle wait after reset release
    localparam int USG_SYNC_STAGES = 2;
    localparam logic [1:0] USG_SETTLE_CYCLES = 2'h3;

    // selector value that assigns the guard function to its terminal
    localparam logic [4:0] USG_GUARD_OPTION = 5'h0D;

    // displayed trip codes
    localparam logic [7:0] USG_CODE_NONE = 8'h00;
    localparam logic [7:0] USG_UNDERVOLTAGE_TRIP_CODE = 8'h09;
    localparam logic [7:0] USG_START_GUARD_TRIP_CODE = 8'h0D;

    // values after reset
    localparam logic [3:0] USG_SYNC_RESET = 4'h0;
    localparam logic [1:0] USG_SETTLE_RESET = 2'h0;
    localparam logic USG_RUN_RESET = 1'b0;

    // advised wait for the controller before asserting run
    localparam int USG_ADVISED_RUN_WAIT_S = 3;

    typedef enum logic [2:0]
    {
        USG_SETTLE,
        USG_IDLE,
        USG_RUN,
        USG_GUARD_TRIP,
        USG_UV_TRIP
    } usg_state_t;

endpackage

// ### usg_ext_ctrl.sv
// usg_ext_ctrl: model of the external control wiring on the run and clear pins.
// assumes pins are plain levels, changed just after a rising edge of clk.
`timescale 1ns/100ps

module usg_ext_ctrl
(
    input wire logic clk,
    output logic run_request,
    output logic fault_clear_input
);
    initial
    begin
        run_request = 1'b0;
        fault_clear_input = 1'b0;
    end

    // a careful controller waits three seconds after power-up; scenarios skip it on purpose
    task automatic set_run(input logic lvl);
        @(posedge clk);
        run_request <= lvl;
    endtask

    // held over three edges so the synchroniser sees the on level before the off
    task automatic pulse_clear();
        @(posedge clk);
        fault_clear_input <= 1'b1;
        repeat (3) @(posedge clk);
        fault_clear_input <= 1'b0;
    endtask
endmodule

// ### usg_unattended_start_guard_tb.sv
// usg_unattended_start_guard_tb: power-up, clear and undervoltage scenarios.
// assumes clk_en high except in the freeze scenario; output latency of 3 edges after a pin change.
`timescale 1ns/100ps

module usg_unattended_start_guard_tb
    import usg_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [4:0] sel = 5'h00;
    logic guard = 1'b0;
    logic uv = 1'b0;
    logic en = 1'b1;
    logic run_request;
    logic fault_clear_input;
    logic drive_run;
    logic trip_active;
    logic [7:0] trip_code;
    int err_count = 0;
    int total_checks = 0;
    localparam logic [9:0] TRIP = {2'h1, USG_START_GUARD_TRIP_CODE};
    localparam logic [9:0] RUN = {2'h2, USG_CODE_NONE};
    localparam logic [9:0] IDLE = 10'h000;
    localparam logic [9:0] UVT = {2'h1, USG_UNDERVOLTAGE_TRIP_CODE};

    always #4 clk = ~clk;

    usg_ext_ctrl i_usg_ext_ctrl (.clk(clk), .run_request(run_request),
        .fault_clear_input(fault_clear_input));

    usg_unattended_start_guard i_usg_unattended_start_guard (.clk(clk), .nrst(nrst),
        .clk_en(en), .input_function_selectors(sel), .guard_terminal(guard),
        .run_request(run_request), .fault_clear_input(fault_clear_input),
        .undervoltage_detect(uv), .drive_run(drive_run), .trip_active(trip_active),
        .trip_code(trip_code));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        if (err_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string what, input logic [9:0] exp);
        total_checks++;
        if ({drive_run, trip_active, trip_code} !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp,
                {drive_run, trip_active, trip_code});
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // pins reach their power-up levels while reset is held
    task automatic power_up(input logic [4:0] s, input logic g, input logic r);
        @(posedge clk);
        nrst <= 1'b0;
        sel <= s;
        guard <= g;
        i_usg_ext_ctrl.set_run(r);
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        settle(6);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_guard_clear();
        power_up(USG_GUARD_OPTION, 1'b1, 1'b1);
        chk("guard trip at power-up", TRIP);
        settle(20);
        chk("guard trip held", TRIP);
        i_usg_ext_ctrl.pulse_clear();
        settle(5);
        chk("resume after clear", RUN);
    endtask

    task automatic t_guard_drop();
        power_up(USG_GUARD_OPTION, 1'b1, 1'b1);
        i_usg_ext_ctrl.set_run(1'b0);
        settle(5);
        chk("trip left by run drop", IDLE);
        i_usg_ext_ctrl.set_run(1'b1);
        settle(5);
        chk("fresh run after drop", RUN);
    endtask

    task automatic t_no_guard();
        power_up(USG_GUARD_OPTION, 1'b0, 1'b1);
        chk("guard pin off", RUN);
        power_up(5'h0C, 1'b1, 1'b1);
        chk("other selector code", RUN);
    endtask

    task automatic t_uv();
        power_up(USG_GUARD_OPTION, 1'b1, 1'b0);
        chk("idle at power-up", IDLE);
        i_usg_ext_ctrl.set_run(1'b1);
        settle(5);
        chk("run from idle", RUN);
        @(posedge clk);
        uv <= 1'b1;
        settle(5);
        chk("undervoltage trip", UVT);
        @(posedge clk);
        uv <= 1'b0;
        settle(5);
        i_usg_ext_ctrl.pulse_clear();
        settle(5);
        chk("guard after uv clear", TRIP);
    endtask

    // pin changes while the enable is low must not move the latched trip
    task automatic t_freeze();
        power_up(USG_GUARD_OPTION, 1'b1, 1'b1);
        @(posedge clk);
        en <= 1'b0;
        i_usg_ext_ctrl.set_run(1'b0);
        settle(8);
        chk("trip frozen while disabled", TRIP);
        @(posedge clk);
        en <= 1'b1;
        settle(5);
        chk("trip left after enable", IDLE);
        i_usg_ext_ctrl.pulse_clear();
        settle(5);
        chk("clear ignored in idle", IDLE);
    endtask

    initial
    begin
        t_guard_clear();
        t_guard_drop();
        t_no_guard();
        t_uv();
        t_freeze();
        tally_and_finish();
    end
endmodule
